// file: rtl/cc_timer_pkg.sv
// constants and carrier types for the control-channel window timers
// assumes a single 200 MHz clock domain; pixel and bit ticks arrive as enables
package cc_timer_pkg;
  localparam logic [7:0] START_CFG_OFFSET = 8'h02;
  localparam logic [7:0] END_CFG_OFFSET   = 8'h03;
  localparam logic [7:0] START_CFG_RESET  = 8'ha0;
  localparam logic [7:0] END_CFG_RESET    = 8'ha0;
  localparam logic [3:0] DIV_MIN_CODE     = 4'h4;
  localparam logic [15:0] DIV_MIN_RATIO   = 16'h0010;
  localparam logic [6:0] COMEBACK_STEP    = 7'h10;
  localparam logic [14:0] SHORT_SYNC_LO   = 15'h0222;
  localparam logic [14:0] SHORT_SYNC_HI   = 15'h0442;
  localparam logic [14:0] LONG_SYNC_WORDS = 15'h4402;
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          T1_FIXED_PS     = 2500000;
  localparam int          T1_FIXED_CYC    = T1_FIXED_PS / CLK_PERIOD_PS;
  localparam logic [1:0]  SYNC_WORDS      = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_END   = 5'b00100,
    ST_SHAKE = 5'b01000,
    ST_TRAIN = 5'b10000
  } cc_state_t;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    cc_state_t   state;
    logic [7:0]  start_cfg;
    logic [7:0]  end_cfg;
    logic [15:0] div_cnt;
    logic [4:0]  tick_cnt;
    logic [6:0]  cb_cnt;
    logic        periph_en;
    logic        proto_sel;
    logic        cc_enable;
    logic        lock_frame;
    logic        long_train;
    logic [14:0] train_cnt;
    logic [1:0]  sync_cnt;
    logic        video;
  } cc_regs_t;
endpackage

// file: rtl/cc_window_timers.sv
// control-channel window timers: start/end timeouts, closure, training pick
// assumes pixel_tick_i and uart_bit_tick_i are single-cycle enables in clk_i
`timescale 1ns/1ps
// Functional notes
// - close channel if host silent past start timeout
// - start divider from config bits 7:4
// - start counter expires at count plus one
// - reset start timeout equals 1024 pixel clocks
// - host activity stops start, runs end timer
// - end divider from config bits 7:4
// - end counter expires at count plus one
// - link activity clears end count
// - silence for end period closes channel
// - reset end timeout equals 1024 pixel clocks
// - vsync edge plus three syncs opens channel
// - start expiry drops enable
// - end frame after sync closes, base only
// - lock frame sent only if errors within threshold
// - short training on lock frame, else long
// - vsync deassert never closes channel
// - vsync to enable delay bounded
// - bypass held until comeback timer expiry
// - comeback code times sixteen bit times, zero never
// - comeback expiry clears peripheral enable
// - mode follows enable and protocol select
// - short pattern 546 or 1090 words
// - long pattern 17410 words
// - bit reference resyncs on sync frame
module cc_window_timers (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  pixel_tick_i,
  input  wire logic                  uart_bit_tick_i,
  input  wire logic                  sync_frame_i,
  input  wire logic                  vsync_edge_i,
  input  wire logic                  sync_word_i,
  input  wire logic                  host_activity_i,
  input  wire logic                  camera_activity_i,
  input  wire logic                  end_frame_i,
  input  wire logic                  errors_ok_i,
  input  wire logic                  lock_frame_rx_i,
  input  wire logic [1:0]            pixel_rate_range_i,
  input  wire logic [2:0]            comeback_code_i,
  input  wire logic                  mode_write_i,
  input  wire logic                  mode_periph_en_i,
  input  wire logic                  mode_proto_sel_i,
  input  wire cc_timer_pkg::reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  output logic                       control_channel_enable_o,
  output logic                       bypass_mode_o,
  output logic                       i2c_path_en_o,
  output logic                       send_lock_frame_o,
  output logic                       training_o,
  output logic                       long_training_o,
  output logic                       video_phase_o
);
  import cc_timer_pkg::*;

  cc_regs_t r_r;
  cc_regs_t r_nxt;
  logic [15:0] ratio;
  logic [3:0]  code;
  logic [3:0]  limit;
  logic        bypass;
  logic        activity;
  logic        expire;
  logic [6:0]  cb_limit;
  logic [14:0] train_len;

  function automatic logic [15:0] div_ratio(input logic [3:0] c);
    logic [15:0] v;
    v = DIV_MIN_RATIO;
    if (c > DIV_MIN_CODE) begin
      v = DIV_MIN_RATIO << (c - DIV_MIN_CODE);
    end
    return v;
  endfunction

  always_comb begin
    r_nxt     = r_r;
    bypass    = r_r.periph_en && !r_r.proto_sel;
    activity  = host_activity_i || (bypass && camera_activity_i);
    code      = (r_r.state == ST_END) ? r_r.end_cfg[7:4] : r_r.start_cfg[7:4];
    limit     = (r_r.state == ST_END) ? r_r.end_cfg[3:0] : r_r.start_cfg[3:0];
    ratio     = div_ratio(code);
    expire    = 1'b0;
    cb_limit  = COMEBACK_STEP * {4'h0, comeback_code_i};
    train_len = LONG_SYNC_WORDS;
    if (!r_r.long_train) begin
      train_len = pixel_rate_range_i[1] ? SHORT_SYNC_HI : SHORT_SYNC_LO;
    end
    send_lock_frame_o = 1'b0;

    if (reg_req_i.write && r_r.state != ST_START && r_r.state != ST_END) begin
      if (reg_req_i.addr == START_CFG_OFFSET) begin
        r_nxt.start_cfg = reg_req_i.wdata;
      end
      if (reg_req_i.addr == END_CFG_OFFSET) begin
        r_nxt.end_cfg = reg_req_i.wdata;
      end
    end
    if (mode_write_i) begin
      r_nxt.periph_en = mode_periph_en_i;
      r_nxt.proto_sel = mode_proto_sel_i;
      r_nxt.cb_cnt    = 7'h00;
    end

    // bypass lifetime counts bit ticks that restart on host activity or a sync frame
    if (bypass && !mode_write_i) begin
      if (host_activity_i || sync_frame_i) begin
        r_nxt.cb_cnt = 7'h00;
      end else if (uart_bit_tick_i && comeback_code_i != 3'h0) begin
        if (r_r.cb_cnt + 7'h01 >= cb_limit) begin
          r_nxt.periph_en = 1'b0;
          r_nxt.cb_cnt    = 7'h00;
        end else begin
          r_nxt.cb_cnt = r_r.cb_cnt + 7'h01;
        end
      end
    end

    if (pixel_tick_i && (r_r.state == ST_START || r_r.state == ST_END)) begin
      if (r_r.div_cnt + 16'h0001 >= ratio) begin
        r_nxt.div_cnt = 16'h0000;
        if (r_r.tick_cnt + 5'h01 >= {1'b0, limit} + 5'h01) begin
          expire = 1'b1;
        end else begin
          r_nxt.tick_cnt = r_r.tick_cnt + 5'h01;
        end
      end else begin
        r_nxt.div_cnt = r_r.div_cnt + 16'h0001;
      end
    end

    case (r_r.state)
      ST_IDLE: begin
        r_nxt.cc_enable = 1'b0;
        if (vsync_edge_i) begin
          r_nxt.sync_cnt = 2'h0;
          r_nxt.video    = 1'b0;
        end else if (sync_word_i && !r_r.video) begin
          if (r_r.sync_cnt + 2'h1 == SYNC_WORDS) begin
            r_nxt.state     = ST_START;
            r_nxt.cc_enable = 1'b1;
            r_nxt.div_cnt   = 16'h0000;
            r_nxt.tick_cnt  = 5'h00;
            r_nxt.sync_cnt  = 2'h0;
          end else begin
            r_nxt.sync_cnt = r_r.sync_cnt + 2'h1;
          end
        end
      end
      ST_START: begin
        if (activity) begin
          r_nxt.state    = ST_END;
          r_nxt.div_cnt  = 16'h0000;
          r_nxt.tick_cnt = 5'h00;
        end else if (expire) begin
          r_nxt.state     = ST_SHAKE;
          r_nxt.cc_enable = 1'b0;
        end
      end
      ST_END: begin
        if (end_frame_i && r_r.lock_frame && !bypass) begin
          r_nxt.state     = ST_SHAKE;
          r_nxt.cc_enable = 1'b0;
        end else if (activity) begin
          r_nxt.div_cnt  = 16'h0000;
          r_nxt.tick_cnt = 5'h00;
        end else if (expire) begin
          r_nxt.state     = ST_SHAKE;
          r_nxt.cc_enable = 1'b0;
        end
      end
      ST_SHAKE: begin
        send_lock_frame_o = errors_ok_i;
        r_nxt.long_train  = !(errors_ok_i || lock_frame_rx_i);
        r_nxt.state       = ST_TRAIN;
        r_nxt.train_cnt   = 15'h0000;
      end
      ST_TRAIN: begin
        if (pixel_tick_i) begin
          if (r_r.train_cnt + 15'h0001 >= train_len) begin
            r_nxt.state = ST_IDLE;
            r_nxt.video = 1'b1;
          end else begin
            r_nxt.train_cnt = r_r.train_cnt + 15'h0001;
          end
        end
      end
      default: begin
        r_nxt.state = ST_IDLE;
      end
    endcase

    // a sync frame arms the end frame that follows it
    if (sync_frame_i) begin
      r_nxt.lock_frame = 1'b1;
    end else if (end_frame_i || host_activity_i) begin
      r_nxt.lock_frame = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r <= '{state: ST_IDLE, start_cfg: START_CFG_RESET,
               end_cfg: END_CFG_RESET, default: '0};
    end else if (clk_en_i) begin
      r_r <= r_nxt;
    end
  end

  always_comb begin
    reg_rdata_o = 8'h00;
    if (reg_req_i.addr == START_CFG_OFFSET) begin
      reg_rdata_o = r_r.start_cfg;
    end else if (reg_req_i.addr == END_CFG_OFFSET) begin
      reg_rdata_o = r_r.end_cfg;
    end
  end

  // vsync has no path into the close logic at all
  assign control_channel_enable_o = r_r.cc_enable;
  assign bypass_mode_o            = bypass;
  assign i2c_path_en_o            = r_r.periph_en && r_r.proto_sel;
  assign training_o               = (r_r.state == ST_TRAIN);
  assign long_training_o          = r_r.long_train;
  assign video_phase_o            = r_r.video;

  // window opening and the enable that marks it
  a_enable_window: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    control_channel_enable_o == (r_r.state == ST_START || r_r.state == ST_END))
    else $error("enable outside open window");
  a_open_enable: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(r_r.state == ST_START) |-> control_channel_enable_o &&
    $past(r_r.state) == ST_IDLE) else $error("window opened badly");
  a_open_prompt: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_IDLE && !vsync_edge_i && sync_word_i &&
    !r_r.video && r_r.sync_cnt == 2'h2) |=> control_channel_enable_o)
    else $error("enable late after third sync word");
  a_vsync_keep: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_START && vsync_edge_i && !activity &&
    !expire) |=> r_r.state == ST_START && control_channel_enable_o)
    else $error("vsync disturbed open window");

  // start and end timers; config must not move under a running count
  a_start_expiry: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_START && expire && !activity)
    |=> !control_channel_enable_o) else $error("start expiry kept enable");
  a_activity_end: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_START && activity)
    |=> r_r.state == ST_END && r_r.tick_cnt == 5'h00)
    else $error("activity did not start end timer");
  a_end_clear: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_END && activity && !end_frame_i)
    |=> r_r.div_cnt == 16'h0000 && r_r.tick_cnt == 5'h00)
    else $error("end count not cleared");
  a_end_silence: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_END && expire && !activity && !end_frame_i)
    |=> r_r.state == ST_SHAKE) else $error("end expiry missed");
  a_ef_close: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_END && end_frame_i && r_r.lock_frame &&
    !bypass) |=> r_r.state == ST_SHAKE && !control_channel_enable_o)
    else $error("armed end frame did not close");
  a_bypass_ef: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_END && bypass && !activity && !expire)
    |=> r_r.state == ST_END) else $error("end frame closed bypass");
  a_tick_bound: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (r_r.state == ST_START) |-> r_r.tick_cnt <= {1'b0, r_r.start_cfg[3:0]})
    else $error("start count overran");
  a_end_bound: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (r_r.state == ST_END) |-> r_r.tick_cnt <= {1'b0, r_r.end_cfg[3:0]})
    else $error("end count overran");
  a_div_bound: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (r_r.state == ST_START || r_r.state == ST_END) |-> r_r.div_cnt < ratio)
    else $error("divider overran its ratio");
  a_cfg_frozen: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && (r_r.state == ST_START || r_r.state == ST_END))
    |=> $stable(r_r.start_cfg) && $stable(r_r.end_cfg))
    else $error("config changed in open window");

  // bypass lifetime
  a_cb_never: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && comeback_code_i == 3'h0 && bypass && !mode_write_i)
    |=> r_r.periph_en) else $error("code zero left bypass");
  a_cb_expire: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && bypass && !mode_write_i && !host_activity_i &&
    !sync_frame_i && uart_bit_tick_i && comeback_code_i != 3'h0 &&
    r_r.cb_cnt + 7'h01 >= cb_limit) |=> !r_r.periph_en)
    else $error("comeback expiry kept bypass");

  // handshake and training
  a_train_pick: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_SHAKE && lock_frame_rx_i)
    |=> !long_training_o) else $error("long training with lock");
  a_train_done: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_TRAIN && pixel_tick_i &&
    r_r.train_cnt + 15'h0001 >= train_len)
    |=> r_r.state == ST_IDLE && video_phase_o)
    else $error("training overran its length");
  a_train_hold: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && r_r.state == ST_TRAIN &&
    r_r.train_cnt + 15'h0001 < train_len)
    |=> r_r.state == ST_TRAIN) else $error("training cut short");
endmodule

// file: verification/host_model.sv
// host controller model on the control channel
// assumes one-cycle commands on talk_i and close_i from the bench
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_i,
  input  wire logic enable_i,
  input  wire logic talk_i,
  input  wire logic close_i,
  output logic      activity_o,
  output logic      sync_frame_o,
  output logic      end_frame_o
);
  initial begin
    activity_o = 1'b0;
    sync_frame_o = 1'b0;
    end_frame_o = 1'b0;
  end
  // speaks only inside an open window; a late command is dropped
  always @(posedge clk_i) begin
    if (talk_i && enable_i) begin
      #1 activity_o = 1'b1;
      @(posedge clk_i) #1 activity_o = 1'b0;
    end else if (close_i && enable_i) begin
      #1 sync_frame_o = 1'b1;
      @(posedge clk_i) #1 sync_frame_o = 1'b0;
      end_frame_o = 1'b1;
      @(posedge clk_i) #1 end_frame_o = 1'b0;
    end
  end
endmodule

// file: verification/cc_window_timers_tb.sv
// self-checking bench for the control-channel window timers
// assumes the host model on the far side and a 200 MHz clk_i
`timescale 1ns/1ps
module cc_window_timers_tb;
  import cc_timer_pkg::*;
  logic       clk_i, reset_n_i, clk_en_i, pixel_tick_i, uart_bit_tick_i;
  logic       sync_frame_i, vsync_edge_i, sync_word_i, host_activity_i;
  logic       camera_activity_i, end_frame_i, errors_ok_i, lock_frame_rx_i;
  logic [1:0] pixel_rate_range_i;
  logic [2:0] comeback_code_i, phase;
  logic       mode_write_i, mode_periph_en_i, mode_proto_sel_i, talk, close;
  reg_req_t   reg_req_i;
  logic [7:0] rdata;
  logic       en, byp, i2c, lock_tx, train, long_train, video;
  int         fails, samples_checked, cycles, n;

  cc_window_timers i_dut (.clk_i, .reset_n_i, .clk_en_i, .pixel_tick_i,
    .uart_bit_tick_i, .sync_frame_i, .vsync_edge_i, .sync_word_i,
    .host_activity_i, .camera_activity_i, .end_frame_i, .errors_ok_i,
    .lock_frame_rx_i, .pixel_rate_range_i, .comeback_code_i, .mode_write_i,
    .mode_periph_en_i, .mode_proto_sel_i, .reg_req_i, .reg_rdata_o(rdata),
    .control_channel_enable_o(en), .bypass_mode_o(byp),
    .i2c_path_en_o(i2c), .send_lock_frame_o(lock_tx), .training_o(train),
    .long_training_o(long_train), .video_phase_o(video));
  host_model i_host (.clk_i, .enable_i(en), .talk_i(talk), .close_i(close),
    .activity_o(host_activity_i), .sync_frame_o(sync_frame_i),
    .end_frame_o(end_frame_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // pixel tick every second cycle, bit tick every eighth
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    phase <= phase + 3'h1;
    pixel_tick_i <= #1 phase[0];
    uart_bit_tick_i <= #1 (phase == 3'h7);
    if (cycles == 90000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic near(input int seen, input int exp);
    check(seen >= exp - 2 && seen <= exp + 2, 1);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return en;
      1: return train;
      2: return byp;
      3: return video;
      default: return lock_tx;
    endcase
  endfunction
  // counts ticks of the relevant clock while waiting, bounded by lim cycles
  task automatic wait_val(input int sel, input logic v, input int lim);
    int c;
    n = 0;
    c = 0;
    while (pick(sel) !== v && c < lim) begin
      cyc(1);
      c++;
      n += (sel == 2) ? uart_bit_tick_i : pixel_tick_i;
    end
    check(pick(sel), v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req_i = '{1'b1, a, d};
    cyc(1);
    reg_req_i.write = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_req_i.addr = a;
    #1 check(rdata, exp);
    cyc(1);
  endtask
  task automatic pulse_talk();
    talk = 1'b1;
    cyc(1);
    talk = 1'b0;
  endtask
  task automatic set_mode(input logic e, input logic s);
    mode_periph_en_i = e;
    mode_proto_sel_i = s;
    mode_write_i = 1'b1;
    cyc(1);
    mode_write_i = 1'b0;
    cyc(1);
  endtask
  task automatic open_window();
    vsync_edge_i = 1'b1;
    cyc(1);
    vsync_edge_i = 1'b0;
    sync_word_i = 1'b1;
    cyc(3);
    sync_word_i = 1'b0;
    wait_val(0, 1'b1, 500);
  endtask

  initial begin
    {reset_n_i, pixel_tick_i, uart_bit_tick_i, vsync_edge_i, sync_word_i} = 0;
    {camera_activity_i, mode_write_i, mode_periph_en_i, talk, close} = 0;
    {mode_proto_sel_i, pixel_rate_range_i, comeback_code_i, phase} = 0;
    {fails, samples_checked, cycles} = 0;
    reg_req_i = '0;
    clk_en_i = 1'b1;
    errors_ok_i = 1'b1;
    lock_frame_rx_i = 1'b1;
    cyc(10);
    reset_n_i = 1'b1;
    cyc(1);
    rd_chk(START_CFG_OFFSET, START_CFG_RESET);
    rd_chk(END_CFG_OFFSET, END_CFG_RESET);
    rd_chk(8'h05, 8'h00);
    open_window();
    wait_val(0, 1'b0, 3000);
    near(n, 1024);
    wait_val(4, 1'b1, 4);
    wait_val(1, 1'b1, 4);
    check(long_train, 1'b0);
    wait_val(1, 1'b0, 3000);
    near(n, 546);
    check(video, 1'b1);
    wr(START_CFG_OFFSET, 8'h21);
    rd_chk(START_CFG_OFFSET, 8'h21);
    wr(END_CFG_OFFSET, 8'h52);
    rd_chk(END_CFG_OFFSET, 8'h52);
    pixel_rate_range_i = 2'h2;
    open_window();
    wait_val(0, 1'b0, 200);
    near(n, 32);
    wait_val(1, 1'b1, 6);
    wait_val(1, 1'b0, 3000);
    near(n, 1090);
    errors_ok_i = 1'b0;
    lock_frame_rx_i = 1'b0;
    open_window();
    pulse_talk();
    wr(START_CFG_OFFSET, 8'hff);
    rd_chk(START_CFG_OFFSET, 8'h21);
    cyc(100);
    check(en, 1'b1);
    pulse_talk();
    wait_val(0, 1'b0, 400);
    near(n, 96);
    // the handshake cycle: closed, not yet training, no lock offered
    check({en, train}, 2'b00);
    check(lock_tx, 1'b0);
    wait_val(1, 1'b1, 4);
    check(long_train, 1'b1);
    wait_val(1, 1'b0, 40000);
    near(n, 17410);
    errors_ok_i = 1'b1;
    open_window();
    pulse_talk();
    cyc(4);
    close = 1'b1;
    cyc(1);
    close = 1'b0;
    wait_val(0, 1'b0, 6);
    wait_val(3, 1'b1, 3000);
    comeback_code_i = 3'h1;
    open_window();
    vsync_edge_i = 1'b1;
    cyc(1);
    vsync_edge_i = 1'b0;
    check(en, 1'b1);
    set_mode(1'b1, 1'b1);
    check({i2c, byp}, 2'b10);
    set_mode(1'b1, 1'b0);
    check({i2c, byp}, 2'b01);
    pulse_talk();
    wait_val(2, 1'b0, 300);
    near(n, 16);
    comeback_code_i = 3'h0;
    set_mode(1'b1, 1'b0);
    cyc(300);
    check(byp, 1'b1);
    // a frozen clock enable must hold bypass past the comeback period
    comeback_code_i = 3'h1;
    clk_en_i = 1'b0;
    cyc(300);
    check(byp, 1'b1);
    clk_en_i = 1'b1;
    wait_val(2, 1'b0, 300);
    near(n, 16);
    finish_test();
  end
endmodule
